//--- design/bps_supervisor.sv
// Protection supervisor: output window, limit calibration, trip sequence
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Window comparator results are ignored throughout soft-start.
// - Power-good stays low until the first window evaluation after soft-start.
// - Below lowest threshold is undervoltage: restart, power-good low.
// - Between lowest and second threshold: low not-good, power-good low.
// - Inside regulation band: good, power-good released.
// - Between upper band and overvoltage threshold: high not-good, power-good low.
// - Above top threshold: overvoltage, power-good low, latch off switching.
// - Overvoltage latch clears only by power-on reset.
// - Current sensing only while the high-side switch is on.
// - Limit calibration runs in startup before soft-start, about 350 us.
// - Calibration yields a 6-bit code stored as the trip value.
// - Limit DAC has 63 steps of 6.51 mV, 403 mV full scale.
// - Counter steps DAC up until calibration comparator crosses, then holds.
// - No crossing by full scale disables current limiting.
// - Stored codes 0 to 10 give a 0 mV limit.
// - On-time counted in 10 ns ticks; 3/4 held for next cycle.
// - Fault when sense exceeds reference before the held 3/4 point.
// - Stored limit doubled during soft-start, normal afterwards.
// - On trip: finish cycle, one half on-time pulse, both switches off.
// - After limit shutdown wait four soft-start times, then soft-start.
// - Soft-start raises reference in 32 equal steps, done after last.
// - A 400 us startup delay precedes soft-start stepping.
module bps_supervisor #(
  parameter int STARTUP_CYC = bps_pkg::STARTUP_CYC,
  parameter int CAL_CYC     = bps_pkg::CAL_CYC,
  parameter int CAL_STEP    = bps_pkg::CAL_STEP_CYC,
  parameter int SS_STEP_CYC = bps_pkg::SS_STEP_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        fb_above_1p00,
  input  wire logic        fb_above_0p88,
  input  wire logic        fb_above_0p72,
  input  wire logic        fb_above_0p60,
  input  wire logic        cal_crossed,
  input  wire logic        switch_node_over,
  input  wire logic        pwm_demand,
  input  wire logic        regulation_ok_in,
  output logic             regulation_ok_out,
  output logic             regulation_ok_out_oe,
  output logic             high_side_switch,
  output logic             low_side_switch,
  output logic             error_amplifier_park,
  output logic [6:0]       limit_dac_code,
  output logic [5:0]       ss_step,
  output logic             restart_request,
  output logic             output_overvoltage,
  output logic             output_undervoltage,
  output logic             current_limit_fault
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_DELAY, ST_SOFT, ST_RUN, ST_TRIP, ST_HALF, ST_WAIT, ST_LATCH
  } bps_state_t;

  localparam int WAIT_CYC = bps_pkg::RETRY_SS_COUNT * bps_pkg::SS_STEPS * SS_STEP_CYC;
  localparam int ONT_W    = bps_pkg::ONT_W;
  localparam int DB       = bps_pkg::DAC_BITS;

  bps_state_t        state;
  logic [31:0]       timer;
  logic [15:0]       cal_div;
  logic [DB-1:0]     cal_code;
  logic              cal_done;
  logic              limit_off;
  logic              ctrl_enable;
  logic [5:0]        sync_q;
  logic              fb_1p00_s;
  logic              fb_0p88_s;
  logic              fb_0p72_s;
  logic              fb_0p60_s;
  logic              cal_s;
  logic              sense_s;
  bps_pkg::bps_win_t win_now;
  bps_pkg::bps_win_t win_class;
  logic              evaluated;
  logic              tick;
  logic              pwm_prev;
  logic              hs_prev;
  logic              next_hs;
  logic              next_ls;
  logic [ONT_W-1:0]  on_cnt;
  logic [ONT_W-1:0]  last_on;
  logic [ONT_W-1:0]  sense_limit;
  logic              sense_window;
  logic              fault;
  logic              pg_release;
  logic [6:0]        next_dac;
  logic              aw_got;
  logic              w_got;
  logic [3:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // Comparator inputs resynchronised before any decision
  bps_sync #(
    .WIDTH (6)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({fb_above_1p00, fb_above_0p88, fb_above_0p72, fb_above_0p60,
               cal_crossed, switch_node_over}),
    .dout    (sync_q)
  );
  assign {fb_1p00_s, fb_0p88_s, fb_0p72_s, fb_0p60_s, cal_s, sense_s} = sync_q;

  // Window classification, highest threshold first
  always_comb
  begin
    if (fb_1p00_s)
      win_now = bps_pkg::WIN_OV;
    else if (fb_0p88_s)
      win_now = bps_pkg::WIN_HIGH;
    else if (fb_0p72_s)
      win_now = bps_pkg::WIN_GOOD;
    else if (fb_0p60_s)
      win_now = bps_pkg::WIN_LOW;
    else
      win_now = bps_pkg::WIN_UV;
  end

  // 10 ns tick from the 5 ns clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick <= 1'b0;
    else
      tick <= ~tick;
  end

  // Main sequencer; the overvoltage latch has no exit but reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state   <= ST_IDLE;
      timer   <= '0;
      ss_step <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          timer   <= '0;
          ss_step <= '0;
          if (ctrl_enable)
            state <= ST_DELAY;
        end
        ST_DELAY:
        begin
          timer <= timer + 32'h1;
          if (!ctrl_enable)
            state <= ST_IDLE;
          else if (timer >= 32'(STARTUP_CYC - 1))
          begin
            state <= ST_SOFT;
            timer <= '0;
          end
        end
        ST_SOFT:
        begin
          timer <= timer + 32'h1;
          if (!ctrl_enable)
            state <= ST_IDLE;
          else if (fault)
            state <= ST_TRIP;
          else if (timer >= 32'(SS_STEP_CYC - 1))
          begin
            timer   <= '0;
            ss_step <= ss_step + 6'h1;
            if (ss_step == 6'(bps_pkg::SS_STEPS - 1))
              state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          timer <= '0;
          if (win_now == bps_pkg::WIN_OV)
            state <= ST_LATCH;
          else if (win_now == bps_pkg::WIN_UV)
          begin
            state   <= ST_SOFT;
            ss_step <= '0;
          end
          else if (fault)
            state <= ST_TRIP;
          else if (!ctrl_enable)
            state <= ST_IDLE;
        end
        ST_TRIP:
        begin
          timer <= '0;
          // Present cycle ends when the next one is demanded
          if (pwm_demand && !pwm_prev)
            state <= ST_HALF;
        end
        ST_HALF:
        begin
          // last_on ticks of 10 ns equal half on-time in 5 ns cycles
          timer <= timer + 32'h1;
          if (timer + 32'h1 >= 32'(last_on))
          begin
            state <= ST_WAIT;
            timer <= '0;
          end
        end
        ST_WAIT:
        begin
          timer <= timer + 32'h1;
          if (timer >= 32'(WAIT_CYC - 1))
          begin
            state   <= ST_SOFT;
            timer   <= '0;
            ss_step <= '0;
          end
        end
        ST_LATCH:
          state <= ST_LATCH;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Limit calibration during the startup delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == ST_IDLE)
    begin
      cal_div   <= '0;
      cal_code  <= '0;
      cal_done  <= 1'b0;
      limit_off <= 1'b0;
    end
    else if (state == ST_DELAY && !cal_done && timer < 32'(CAL_CYC))
    begin
      if (cal_s)
        cal_done <= 1'b1;
      else if (cal_div >= 16'(CAL_STEP - 1))
      begin
        cal_div <= '0;
        if (cal_code == DB'(bps_pkg::DAC_STEPS))
        begin
          cal_done  <= 1'b1;
          limit_off <= 1'b1;
        end
        else
          cal_code <= cal_code + DB'(1);
      end
      else
        cal_div <= cal_div + 16'h1;
    end
    else if (state == ST_DELAY && !cal_done && timer >= 32'(CAL_CYC))
    begin
      cal_done  <= 1'b1;
      limit_off <= 1'b1;
    end
  end

  // DAC reference: ramp while calibrating, doubled in soft-start
  always_comb
  begin
    if (state == ST_DELAY && !cal_done)
      next_dac = {1'b0, cal_code};
    else if (limit_off || cal_code <= DB'(bps_pkg::DAC_DEAD_CODE))
      next_dac = '0;
    else if (state == ST_SOFT)
      next_dac = {cal_code, 1'b0};
    else
      next_dac = {1'b0, cal_code};
  end

  // Gate commands; both off outside active switching
  always_comb
  begin
    case (state)
      ST_SOFT, ST_RUN, ST_TRIP:
      begin
        next_hs = pwm_demand;
        next_ls = ~pwm_demand;
      end
      ST_HALF:
      begin
        next_hs = 1'b1;
        next_ls = 1'b0;
      end
      default:
      begin
        next_hs = 1'b0;
        next_ls = 1'b0;
      end
    endcase
  end

  // Registered gate and DAC outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      high_side_switch     <= 1'b0;
      low_side_switch      <= 1'b0;
      limit_dac_code       <= '0;
      error_amplifier_park <= 1'b0;
      pwm_prev             <= 1'b0;
      hs_prev              <= 1'b0;
    end
    else
    begin
      high_side_switch     <= next_hs;
      low_side_switch      <= next_ls;
      limit_dac_code       <= next_dac;
      error_amplifier_park <= (state == ST_DELAY);
      pwm_prev             <= pwm_demand;
      hs_prev              <= high_side_switch;
    end
  end

  // On-time in 10 ns ticks; 3/4 of it bounds the next sense window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      on_cnt      <= '0;
      last_on     <= '0;
      sense_limit <= '0;
    end
    else if (hs_prev && !high_side_switch)
    begin
      on_cnt      <= '0;
      last_on     <= on_cnt;
      sense_limit <= ONT_W'(({2'b00, on_cnt} * 3) >> 2);
    end
    else if (high_side_switch && tick && on_cnt != '1)
      on_cnt <= on_cnt + ONT_W'(1);
  end

  // Sense window open only with the high side on, before the 3/4 point
  assign sense_window = high_side_switch && (on_cnt < sense_limit);
  // Short codes and a disabled limit never trip
  assign fault = sense_window && sense_s && !limit_off && cal_done
                 && (cal_code > DB'(bps_pkg::DAC_DEAD_CODE))
                 && (state == ST_SOFT || state == ST_RUN);

  // Window register updated only in regulation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      win_class <= bps_pkg::WIN_UV;
      evaluated <= 1'b0;
    end
    else if (state == ST_RUN)
    begin
      win_class <= win_now;
      evaluated <= 1'b1;
    end
    else if (state != ST_LATCH)
      evaluated <= 1'b0;
  end

  // Power-good released only after a good evaluation
  assign pg_release = evaluated && (state == ST_RUN)
                      && (win_class == bps_pkg::WIN_GOOD);

  // Open-drain power-good and event outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      regulation_ok_out_oe <= 1'b1;
      restart_request      <= 1'b0;
      output_overvoltage   <= 1'b0;
      output_undervoltage  <= 1'b0;
      current_limit_fault  <= 1'b0;
    end
    else
    begin
      regulation_ok_out_oe <= ~pg_release;
      restart_request      <= (state == ST_RUN) && (win_now == bps_pkg::WIN_UV);
      output_undervoltage  <= (state == ST_RUN) && (win_now == bps_pkg::WIN_UV);
      current_limit_fault  <= fault;
      if (state == ST_RUN && win_now == bps_pkg::WIN_OV)
        output_overvoltage <= 1'b1;
    end
  end
  assign regulation_ok_out = 1'b0;

  // AXI write: address and data accepted in either order
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bps_pkg::RESP_OKAY;
      ctrl_enable  <= bps_pkg::CTRL_EN_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_got && w_got)
      begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == bps_pkg::OFS_CTRL)
        begin
          s_axi_bresp <= bps_pkg::RESP_OKAY;
          if (w_strb[0])
            ctrl_enable <= w_data[bps_pkg::CTRL_EN_BIT];
        end
        else if (aw_addr == bps_pkg::OFS_STATUS || aw_addr == bps_pkg::OFS_LIMIT
                 || aw_addr == bps_pkg::OFS_ONTIME)
          s_axi_bresp <= bps_pkg::RESP_OKAY;
        else
          s_axi_bresp <= bps_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode
  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      bps_pkg::OFS_CTRL:
        rd_word[bps_pkg::CTRL_EN_BIT] = ctrl_enable;
      bps_pkg::OFS_STATUS:
      begin
        rd_word[bps_pkg::STAT_STATE_LSB +: 4] = 4'(state);
        rd_word[bps_pkg::STAT_WIN_LSB +: 3]   = 3'(win_class);
        rd_word[bps_pkg::STAT_PG_BIT]         = pg_release;
        rd_word[bps_pkg::STAT_OV_BIT]         = output_overvoltage;
        rd_word[bps_pkg::STAT_PIN_BIT]        = regulation_ok_in;
        rd_word[bps_pkg::STAT_STEP_LSB +: 6]  = ss_step;
      end
      bps_pkg::OFS_LIMIT:
      begin
        rd_word[DB-1:0]                = cal_code;
        rd_word[bps_pkg::LIM_DONE_BIT] = cal_done;
        rd_word[bps_pkg::LIM_OFF_BIT]  = limit_off;
      end
      bps_pkg::OFS_ONTIME:
      begin
        rd_word[ONT_W-1:0]                        = last_on;
        rd_word[bps_pkg::ONT_HELD_LSB +: ONT_W]   = sense_limit;
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  // AXI read: one outstanding, data from a register
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= bps_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? bps_pkg::RESP_OKAY : bps_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // bps_supervisor
`default_nettype wire

//--- design/bps_pkg.sv
// Constants and types shared by the buck protection supervisor
`default_nettype none
package bps_pkg;
  // Clock and timebase
  localparam int CLK_MHZ        = 200;
  localparam int TICK_NS        = 10;
  localparam int CLK_NS         = 1000 / CLK_MHZ;
  localparam int TICK_CYC       = TICK_NS / CLK_NS;
  // Startup delay, calibration and soft-start times
  localparam int STARTUP_US     = 400;
  localparam int STARTUP_CYC    = STARTUP_US * CLK_MHZ;
  localparam int CAL_US         = 350;
  localparam int CAL_CYC        = CAL_US * CLK_MHZ;
  localparam int SS_TOTAL_US    = 5120;
  localparam int SS_STEPS       = 32;
  localparam int SS_STEP_CYC    = SS_TOTAL_US * CLK_MHZ / SS_STEPS;
  localparam int RETRY_SS_COUNT = 4;
  // Limit DAC
  localparam int DAC_BITS       = 6;
  localparam int DAC_STEPS      = 63;
  localparam int DAC_STEP_UV    = 6510;
  localparam int DAC_FULL_UV    = 403000;
  localparam int DAC_DEAD_CODE  = 10;
  localparam int CAL_STEP_CYC   = CAL_CYC / DAC_STEPS;
  // On-time counter
  localparam int ONT_W          = 10;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_LIMIT  = 4'h8;
  localparam logic [3:0] OFS_ONTIME = 4'hC;
  // Reset values and field positions
  localparam logic       CTRL_EN_RST    = 1'b0;
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         STAT_STATE_LSB = 0;
  localparam int         STAT_WIN_LSB   = 4;
  localparam int         STAT_PG_BIT    = 8;
  localparam int         STAT_OV_BIT    = 9;
  localparam int         STAT_PIN_BIT   = 10;
  localparam int         STAT_STEP_LSB  = 16;
  localparam int         LIM_DONE_BIT   = 8;
  localparam int         LIM_OFF_BIT    = 9;
  localparam int         ONT_HELD_LSB   = 16;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  // Output window classes
  typedef enum logic [2:0] {WIN_UV, WIN_LOW, WIN_GOOD, WIN_HIGH, WIN_OV} bps_win_t;
endpackage
`default_nettype wire

//--- design/bps_sync.sv
// Two-stage synchroniser for the analog comparator outputs
`timescale 1ns/1ps
`default_nettype none
module bps_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // bps_sync
`default_nettype wire

//--- test/bps_asserts.sv
// Port-level checker for the protection supervisor, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module bps_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       regulation_ok_out_oe,
  input wire logic       high_side_switch,
  input wire logic       low_side_switch,
  input wire logic       error_amplifier_park,
  input wire logic [6:0] limit_dac_code,
  input wire logic [5:0] ss_step,
  input wire logic       restart_request,
  input wire logic       output_undervoltage,
  input wire logic       output_overvoltage,
  input wire logic       current_limit_fault
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Overvoltage latch: sticky, quiet stage, pin pulled low
  a_ov_sticky: assert property (output_overvoltage |=> output_overvoltage)
    else $error("overvoltage latch dropped");
  a_ov_quiet: assert property (output_overvoltage |=> !high_side_switch && !low_side_switch)
    else $error("switching while latched off");
  a_ov_pg_low: assert property (output_overvoltage |=> regulation_ok_out_oe)
    else $error("power good released in overvoltage");
  a_ov_no_retry: assert property (output_overvoltage |-> !restart_request)
    else $error("restart requested while latched");
  // Window is ignored while soft-start steps; no switching in the startup delay
  a_ss_pg_low: assert property (ss_step != 6'h00 && ss_step < 6'h20 |-> regulation_ok_out_oe)
    else $error("power good released in soft-start");
  a_park_quiet: assert property (error_amplifier_park |-> !high_side_switch && !low_side_switch)
    else $error("switching during startup delay");
  // Undervoltage gives one restart pulse and a fresh soft-start
  a_uv_pulse: assert property (restart_request |-> output_undervoltage ##1 !restart_request)
    else $error("restart pulse malformed");
  a_uv_restart: assert property (restart_request |-> ##[1:2] ss_step == 6'h00)
    else $error("restart did not reach step zero");
  // Codes up to ten give no reference on the DAC
  a_dac_dead: assert property (!error_amplifier_park && !$past(error_amplifier_park) |->
    limit_dac_code == 7'h00 || limit_dac_code > 7'h0A)
    else $error("dead-band limit code on the DAC");
  a_ss_steps: assert property ($changed(ss_step) |->
    ss_step == 6'h00 || ss_step == $past(ss_step) + 6'h01)
    else $error("soft-start step skipped");
  // Sense result counts only near a high-side on interval
  a_fault_hs: assert property (current_limit_fault |->
    $past(high_side_switch) || $past(high_side_switch, 2) || $past(high_side_switch, 3))
    else $error("limit fault with high side off");
  c_ov: cover property (output_overvoltage);
  c_fault: cover property (current_limit_fault);
  c_pg_up: cover property (!regulation_ok_out_oe);
endmodule // bps_asserts
bind bps_supervisor bps_asserts u_chk (.*);
`default_nettype wire

//--- test/bps_analog.sv
// Behavioural analog front end: comparators and PWM demand source
`timescale 1ns/1ps
`default_nettype none
module bps_analog (
  input  wire logic        aclk,
  input  wire logic [10:0] fb_mv,
  input  wire logic [6:0]  set_code,
  input  wire logic        sense_hi,
  input  wire logic [5:0]  on_cyc,
  input  wire logic [6:0]  limit_dac_code,
  output logic             fb_above_1p00,
  output logic             fb_above_0p88,
  output logic             fb_above_0p72,
  output logic             fb_above_0p60,
  output logic             cal_crossed,
  output logic             switch_node_over,
  output logic             pwm_demand
);
  logic [5:0] cnt = 6'h00;
  // Window comparators, thresholds in millivolts
  assign fb_above_1p00 = fb_mv > 11'h3E8;
  assign fb_above_0p88 = fb_mv > 11'h370;
  assign fb_above_0p72 = fb_mv > 11'h2D0;
  assign fb_above_0p60 = fb_mv > 11'h258;
  // Out-of-range set code is never crossed by the ramp
  assign cal_crossed = limit_dac_code >= set_code;
  // Stays live with the switch off; masking is the block's job
  assign switch_node_over = sense_hi;
  assign pwm_demand = cnt < on_cyc;
  // Fixed 40-cycle switching period
  always_ff @(posedge aclk)
  begin
    cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
  end
endmodule // bps_analog
`default_nettype wire

//--- test/buck_protection_supervisor_tb.sv
// Self-checking bench for the buck protection supervisor
`timescale 1ns/1ps
`default_nettype none
module buck_protection_supervisor_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [10:0] fb_mv = 11'h12C;
  logic [6:0]  set_code = 7'h14;
  logic        sense_hi = 1'b0;
  logic [5:0]  on_cyc = 6'h10;
  logic [31:0] d;
  logic [10:0] lv [3] = '{11'h28A, 11'h320, 11'h3B6};
  logic [31:0] wexp [3] = '{32'h010, 32'h120, 32'h030};
  logic [6:0]  sc [2] = '{7'h0A, 7'h7F};
  int          num_errors, compares, cyc, flt_n, rr_n;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [6:0]   limit_dac_code;
  wire [5:0]   ss_step;
  wire         fb_above_1p00, fb_above_0p88, fb_above_0p72, fb_above_0p60, cal_crossed;
  wire         switch_node_over, pwm_demand, regulation_ok_out, regulation_ok_out_oe;
  wire         high_side_switch, low_side_switch, error_amplifier_park, restart_request;
  wire         output_overvoltage, output_undervoltage, current_limit_fault;
  // Open-drain pin with pull-up
  wire         regulation_ok_in = !regulation_ok_out_oe;
  bps_supervisor #(.STARTUP_CYC(400), .CAL_CYC(320), .CAL_STEP(4), .SS_STEP_CYC(20)) uut (.*);
  bps_analog u_analog (.*);
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  // Event counters and hang guard
  always @(posedge aclk)
  begin
    cyc++;
    flt_n += current_limit_fault;
    rr_n += restart_request;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    tick(6);
    aresetn <= 1'b1;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", s_axi_rresp, r);
  endtask
  task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] m, e);
    rd(a, bps_pkg::RESP_OKAY);
    chk(nm, d & m, e);
  endtask
  // Main sequence
  initial
  begin
    rst();
    rc("ctrl", bps_pkg::OFS_CTRL, 32'h1, 32'h0);
    rd(4'h2, bps_pkg::RESP_SLVERR);
    wr(bps_pkg::OFS_STATUS, 32'hFFFFFFFF, bps_pkg::RESP_OKAY);
    wr(bps_pkg::OFS_CTRL, 32'h1, bps_pkg::RESP_OKAY);
    tick(100);
    chk("park", {error_amplifier_park, high_side_switch}, 2'b10);
    tick(350);
    chk("ss dac", limit_dac_code, 7'h28);
    chk("ss pg", regulation_ok_out_oe, 1'b1);
    rc("limit", bps_pkg::OFS_LIMIT, 32'h3FF, 32'h114);
    fb_mv <= 11'h320;
    tick(650);
    chk("ss uv", rr_n, 0);
    chk("run dac", limit_dac_code, 7'h14);
    rc("run", bps_pkg::OFS_STATUS, 32'h7FF, 32'h523);
    $display("startup test done");
    foreach (lv[i])
    begin
      fb_mv <= lv[i];
      tick(8);
      rc("window", bps_pkg::OFS_STATUS, 32'h1F0, wexp[i]);
      chk("pg", regulation_ok_out_oe, !wexp[i][8]);
    end
    $display("window test done");
    fb_mv <= 11'h320;
    on_cyc <= 6'h00;
    sense_hi <= 1'b1;
    tick(200);
    chk("hs off", flt_n, 0);
    sense_hi <= 1'b0;
    on_cyc <= 6'h10;
    tick(100);
    rc("ontime", bps_pkg::OFS_ONTIME, 32'h03FF03FF, 32'h00060008);
    sense_hi <= 1'b1;
    tick(200);
    sense_hi <= 1'b0;
    chk("trip", flt_n != 0, 1'b1);
    chk("off", {high_side_switch, low_side_switch}, 2'b00);
    rc("wait", bps_pkg::OFS_STATUS, 32'hF, 32'h6);
    tick(2100);
    rc("still", bps_pkg::OFS_STATUS, 32'hF, 32'h6);
    tick(600);
    rc("retry", bps_pkg::OFS_STATUS, 32'hF, 32'h2);
    $display("limit trip test done");
    tick(700);
    fb_mv <= 11'h12C;
    tick(10);
    chk("uv", {rr_n[1:0], regulation_ok_out_oe, ss_step < 6'h03}, 4'h7);
    fb_mv <= 11'h320;
    tick(700);
    fb_mv <= 11'h44C;
    tick(10);
    chk("ov", {output_overvoltage, high_side_switch, regulation_ok_out_oe, regulation_ok_out},
        4'b1010);
    fb_mv <= 11'h320;
    wr(bps_pkg::OFS_CTRL, 32'h0, bps_pkg::RESP_OKAY);
    wr(bps_pkg::OFS_CTRL, 32'h1, bps_pkg::RESP_OKAY);
    tick(20);
    rc("ov held", bps_pkg::OFS_STATUS, 32'h200, 32'h200);
    $display("fault test done");
    foreach (sc[i])
    begin
      set_code <= sc[i];
      rst();
      chk("ov clear", output_overvoltage, 1'b0);
      wr(bps_pkg::OFS_CTRL, 32'h1, bps_pkg::RESP_OKAY);
      tick(500);
      chk("dead dac", limit_dac_code, 7'h00);
      rc("lim off", bps_pkg::OFS_LIMIT, 32'h200, {sc[i][6], 9'h000});
    end
    $display("calibration test done");
    finish_test();
  end
endmodule // buck_protection_supervisor_tb
`default_nettype wire
